// ---- include/serial_rx_pkg.sv ----
// package: register map, field layout and types of the clocked serial receiver
package serial_rx_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam int          ADDR_W     = 5;
    localparam logic [4:0]  OFS_CTRL   = 5'h00;
    localparam logic [4:0]  OFS_DIV    = 5'h04;
    localparam logic [4:0]  OFS_STATUS = 5'h08;
    localparam logic [4:0]  OFS_DATA   = 5'h0C;
    localparam logic [4:0]  OFS_ISTAT  = 5'h10;
    localparam logic [4:0]  OFS_ICLR   = 5'h14;
    localparam logic [4:0]  OFS_IEN    = 5'h18;
    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int          CTRL_W     = 9;
    localparam int          STAT_NINTH = 0;
    localparam int          STAT_ERR   = 1;
    localparam int          STAT_VALID = 2;
    localparam int          IRQ_W      = 2;
    localparam int          IRQ_DONE   = 0;
    localparam int          IRQ_ERR    = 1;
    localparam logic [8:0]  CTRL_RESET = 9'h000;
    localparam logic [15:0] DIV_RESET  = 16'h0000;
    localparam logic [1:0]  IRQ_RESET  = 2'h0;
    localparam logic [3:0]  LAST_BIT8  = 4'h7;
    localparam logic [3:0]  LAST_BIT9  = 4'h8;

    // control word, bit 0 is port_on
    typedef struct packed {
        logic continuous_receive_enable;
        logic single_receive_enable;
        logic ninth_bit_receive_enable;
        logic high_speed_divisor_select;
        logic wide_divisor_select;
        logic clock_polarity_select;
        logic clock_master_select;
        logic clocked_mode;
        logic port_on;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] divisor_high_byte;
        logic [7:0] divisor_low_byte;
    } divisor_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_LOW  = 2'b01,
        S_HIGH = 2'b11
    } rx_state_t;
endpackage : serial_rx_pkg

// ---- core/sync_master_serial_receiver.sv ----
// design: clocked-master serial receive path with an Avalon-MM register port
//
// Our own choices: the Avalon-MM slave port and the register offsets.
`default_nettype none

module sync_master_serial_receiver
    import serial_rx_pkg::*;
(
    // clock and reset
    input  wire logic                            clk_i,
    input  wire logic                            reset_n_i,
    // avalon-mm slave
    input  wire logic [serial_rx_pkg::ADDR_W-1:0] address_i,
    input  wire logic                            read_i,
    input  wire logic                            write_i,
    input  wire logic [31:0]                     writedata_i,
    output logic      [31:0]                     readdata_o,
    output logic                                 waitrequest_o,
    // interrupt
    output logic                                 irq_o,
    // link pins
    input  wire logic                            serial_data_line_i,
    output logic                                 shift_clock_pin_o,
    output logic                                 shift_clock_pin_oe_o
);
    import serial_rx_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ctrl_t            ctrl_r,    ctrl_nxt;
    divisor_t         div_r,     div_nxt;
    logic [8:0]       word_r,    word_nxt;
    logic             valid_r,   valid_nxt;
    logic             err_r,     err_nxt;
    logic [IRQ_W-1:0] istat_r,   istat_nxt;
    logic [IRQ_W-1:0] ien_r,     ien_nxt;
    logic             wait_r,    wait_nxt;
    logic [31:0]      rdata_r,   rdata_nxt;
    logic             rd_vld_r,  rd_vld_nxt;
    logic             irq_r,     irq_nxt;
    logic             pin_r,     pin_nxt;
    logic             oe_r,      oe_nxt;
    rx_state_t        state_r,   state_nxt;
    logic [15:0]      cnt_r,     cnt_nxt;
    logic [3:0]       bit_r,     bit_nxt;
    logic [8:0]       shift_r,   shift_nxt;
    logic             sck_r,     sck_nxt;
    logic             data_s1_r;
    logic             data_s2_r;
    logic             active;
    logic             sample_evt;
    logic             word_done;
    logic [15:0]      reload;
    logic             accept;
    logic             data_take;
    logic             err_set;

    // ----------------------------------------------------------------
    // receiver engine
    // ----------------------------------------------------------------
    // only the low byte counts unless the wide divisor is selected
    assign reload = ctrl_r.wide_divisor_select ? div_r
                    : {8'h00, div_r.divisor_low_byte};
    assign active = ctrl_r.port_on && ctrl_r.clocked_mode
                    && ctrl_r.clock_master_select
                    && (ctrl_r.single_receive_enable
                        || ctrl_r.continuous_receive_enable);

    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        bit_nxt    = bit_r;
        shift_nxt  = shift_r;
        sck_nxt    = sck_r;
        sample_evt = 1'b0;
        word_done  = 1'b0;
        case (state_r)
            S_IDLE: begin
                sck_nxt = 1'b0;
                cnt_nxt = 16'h0000;
                bit_nxt = 4'h0;
                if (active) begin
                    state_nxt = S_LOW;
                end
            end
            S_LOW: begin
                if (!active) begin
                    state_nxt = S_IDLE;
                    sck_nxt   = 1'b0;
                end else if (cnt_r == reload) begin
                    cnt_nxt   = 16'h0000;
                    sck_nxt   = 1'b1;
                    state_nxt = S_HIGH;
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            S_HIGH: begin
                if (!active) begin
                    state_nxt = S_IDLE;
                    sck_nxt   = 1'b0;
                end else if (cnt_r == reload) begin
                    cnt_nxt    = 16'h0000;
                    sck_nxt    = 1'b0;
                    sample_evt = 1'b1;
                    shift_nxt[bit_r] = data_s2_r;
                    state_nxt  = S_LOW;
                    bit_nxt    = bit_r + 4'h1;
                    if (bit_r == (ctrl_r.ninth_bit_receive_enable
                                  ? LAST_BIT9 : LAST_BIT8)) begin
                        word_done = 1'b1;
                        bit_nxt   = 4'h0;
                        if (!ctrl_r.continuous_receive_enable) begin
                            state_nxt = S_IDLE;
                        end
                    end
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            default: begin
                state_nxt = S_IDLE;
                sck_nxt   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r   <= S_IDLE;
            cnt_r     <= 16'h0000;
            bit_r     <= 4'h0;
            shift_r   <= 9'h000;
            sck_r     <= 1'b0;
            data_s1_r <= 1'b0;
            data_s2_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            bit_r     <= bit_nxt;
            shift_r   <= shift_nxt;
            sck_r     <= sck_nxt;
            data_s1_r <= serial_data_line_i;
            data_s2_r <= data_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // register file and bus slave
    // ----------------------------------------------------------------
    // one wait cycle: readdata is built while waitrequest is high
    assign accept    = (read_i || write_i) && !wait_r;
    // a data read only frees the word if the word was valid when sampled,
    // so a word landing between sample and accept is not thrown away
    assign data_take = accept && read_i && rd_vld_r
                       && (address_i == OFS_DATA);
    // overrun: previous word still unread, new word is dropped
    assign err_set   = word_done && valid_r && !data_take;

    always_comb begin
        ctrl_nxt   = ctrl_r;
        div_nxt    = div_r;
        word_nxt   = word_r;
        valid_nxt  = valid_r;
        err_nxt    = err_r;
        ien_nxt    = ien_r;
        istat_nxt  = istat_r;
        rdata_nxt  = rdata_r;
        rd_vld_nxt = rd_vld_r;
        wait_nxt   = !((read_i || write_i) && wait_r);
        if (word_done && !ctrl_r.continuous_receive_enable) begin
            ctrl_nxt.single_receive_enable = 1'b0;
        end
        if (accept && write_i) begin
            case (address_i)
                OFS_CTRL: ctrl_nxt = ctrl_t'(writedata_i[CTRL_W-1:0]);
                OFS_DIV:  div_nxt  = divisor_t'(writedata_i[15:0]);
                OFS_ICLR: istat_nxt = istat_r & ~writedata_i[IRQ_W-1:0];
                OFS_IEN:  ien_nxt  = writedata_i[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
        if (ctrl_r.continuous_receive_enable
            && !ctrl_nxt.continuous_receive_enable) begin
            err_nxt = 1'b0;
        end
        if (data_take) begin
            valid_nxt = 1'b0;
        end
        if (word_done && !err_set) begin
            // an 8-bit word must not show a stale ninth bit from earlier
            word_nxt  = {shift_nxt[8] & ctrl_r.ninth_bit_receive_enable,
                         shift_nxt[7:0]};
            valid_nxt = 1'b1;
        end
        if (err_set) begin
            err_nxt = 1'b1;
        end
        istat_nxt = istat_nxt | {err_set, word_done};
        if (read_i && wait_r) begin
            rd_vld_nxt = valid_r;
            case (address_i)
                OFS_CTRL:   rdata_nxt = {23'h000000, ctrl_r};
                OFS_DIV:    rdata_nxt = {16'h0000, div_r};
                OFS_STATUS: rdata_nxt = {29'h00000000, valid_r, err_r,
                                         word_r[8]};
                OFS_DATA:   rdata_nxt = {24'h000000, word_r[7:0]};
                OFS_ISTAT:  rdata_nxt = {30'h00000000, istat_r};
                OFS_IEN:    rdata_nxt = {30'h00000000, ien_r};
                default:    rdata_nxt = 32'h00000000;
            endcase
        end
        irq_nxt = |(istat_nxt & ien_nxt);
        pin_nxt = sck_nxt ^ ctrl_nxt.clock_polarity_select;
        oe_nxt  = ctrl_nxt.port_on && ctrl_nxt.clock_master_select;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r   <= ctrl_t'(CTRL_RESET);
            div_r    <= divisor_t'(DIV_RESET);
            word_r   <= 9'h000;
            valid_r  <= 1'b0;
            err_r    <= 1'b0;
            istat_r  <= IRQ_RESET;
            ien_r    <= IRQ_RESET;
            wait_r   <= 1'b1;
            rdata_r  <= 32'h00000000;
            rd_vld_r <= 1'b0;
            irq_r    <= 1'b0;
            pin_r    <= 1'b0;
            oe_r     <= 1'b0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            div_r    <= div_nxt;
            word_r   <= word_nxt;
            valid_r  <= valid_nxt;
            err_r    <= err_nxt;
            istat_r  <= istat_nxt;
            ien_r    <= ien_nxt;
            wait_r   <= wait_nxt;
            rdata_r  <= rdata_nxt;
            rd_vld_r <= rd_vld_nxt;
            irq_r    <= irq_nxt;
            pin_r    <= pin_nxt;
            oe_r     <= oe_nxt;
        end
    end

    assign readdata_o           = rdata_r;
    assign waitrequest_o        = wait_r;
    assign irq_o                = irq_r;
    assign shift_clock_pin_o    = pin_r;
    assign shift_clock_pin_oe_o = oe_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    logic ctrl_wr;
    assign ctrl_wr = accept && write_i && (address_i == OFS_CTRL);

    sequence s_fall;
        sck_r ##1 !sck_r;
    endsequence

    a_start_gated: assert property (
        (state_r == S_IDLE) ##1 (state_r != S_IDLE)
        |-> $past(active))
        else $error("reception started without a receive enable");
    a_sample_falling: assert property (
        sample_evt |-> s_fall)
        else $error("data sampled away from a shift clock fall");
    a_single_stops: assert property (
        word_done && !ctrl_r.continuous_receive_enable
        |=> state_r == S_IDLE && !sck_r)
        else $error("single reception did not stop after one word");
    a_cont_goes_on: assert property (
        word_done && ctrl_r.continuous_receive_enable && !ctrl_wr
        |=> state_r == S_LOW ##1 state_r != S_IDLE)
        else $error("continuous reception halted");
    a_cont_wins: assert property (
        word_done && ctrl_r.continuous_receive_enable
        && ctrl_r.single_receive_enable && !ctrl_wr
        |=> ctrl_r.single_receive_enable)
        else $error("single enable acted while continuous was set");
    a_clock_invert: assert property (
        (state_r == S_IDLE && ctrl_r.clock_polarity_select && !ctrl_wr)[*2]
        |-> shift_clock_pin_o)
        else $error("inverted idle shift clock not high");
    a_ninth_bit: assert property (
        word_done && !err_set && ctrl_r.ninth_bit_receive_enable
        |=> word_r[8] == $past(data_s2_r) && valid_r)
        else $error("ninth bit not stored");
    a_irq_gate: assert property (
        word_done |=> istat_r[IRQ_DONE]
        ##1 (irq_o == ien_r[IRQ_DONE] || ien_r[IRQ_ERR]))
        else $error("done flag or interrupt gating wrong");
    a_error_clear: assert property (
        ctrl_wr && ctrl_r.continuous_receive_enable
        && !writedata_i[CTRL_W-1] && !err_set
        |=> !err_r)
        else $error("error not cleared by continuous enable clear");
    a_auto_clear: assert property (
        word_done && !ctrl_r.continuous_receive_enable && !ctrl_wr
        |=> !ctrl_r.single_receive_enable)
        else $error("single enable not cleared after word");
    a_clock_idle: assert property (
        !active ##1 !active |-> !sck_r && state_r == S_IDLE)
        else $error("shift clock ran without a receive enable");
    a_bus_answer: assert property (
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("bus request not answered in one cycle");
endmodule : sync_master_serial_receiver

`default_nettype wire

// ---- bench/serial_slave_model.sv ----
// bench: external clocked slave that shifts a bit stream out on our clock
`default_nettype none
module serial_slave_model (
    // clocks seen from outside
    input  wire logic        clk_i,
    input  wire logic        shift_clock_pin_i,
    // bench control
    input  wire logic        invert_i,
    input  wire logic        load_i,
    input  wire logic [35:0] stream_i,
    input  wire logic [5:0]  len_i,
    // data towards the receiver
    output logic             data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       prev_r = 1'b0;
    logic [5:0] idx_r  = 6'h00;
    // new bit on each rising edge of the shift clock, so it is
    // steady through the following falling edge where it is sampled
    always @(posedge clk_i) begin
        prev_r <= shift_clock_pin_i ^ invert_i;
        if (load_i) begin
            idx_r  <= 6'h00;
            data_o <= 1'b0;
        end else if ((shift_clock_pin_i ^ invert_i) && !prev_r) begin
            if (idx_r < len_i) begin
                data_o <= stream_i[idx_r];
                idx_r  <= idx_r + 6'h01;
            end else begin
                // past the stream: keep moving so stale data never matches
                data_o <= ~data_o;
            end
        end
    end
endmodule : serial_slave_model
`default_nettype wire

// ---- bench/sync_master_serial_receiver_tb.sv ----
// bench: self-checking testbench of the clocked-master serial receiver
`default_nettype none
module sync_master_serial_receiver_tb import serial_rx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_i     = 1'b0;
    logic              reset_n_i = 1'b0;
    logic [ADDR_W-1:0] address   = 5'h00;
    logic              rd        = 1'b0;
    logic              wr        = 1'b0;
    logic [31:0]       wdata     = 32'h0;
    logic [31:0]       rdata;
    logic              wait_req, irq, sclk, sclk_oe, sdata;
    logic              inv = 1'b0;
    logic              load = 1'b0;
    logic [35:0]       stream = 36'h0;
    logic [5:0]        len = 6'h00;
    int                err_total = 0;
    int                cmp_count = 0;

    always #2.5 clk_i = ~clk_i;

    sync_master_serial_receiver dut_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .address_i(address),
        .read_i(rd), .write_i(wr), .writedata_i(wdata),
        .readdata_o(rdata), .waitrequest_o(wait_req), .irq_o(irq),
        .serial_data_line_i(sdata), .shift_clock_pin_o(sclk),
        .shift_clock_pin_oe_o(sclk_oe));

    serial_slave_model slave_u (
        .clk_i(clk_i), .shift_clock_pin_i(sclk), .invert_i(inv),
        .load_i(load), .stream_i(stream), .len_i(len), .data_o(sdata));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // request held until the edge where waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        address <= a;
        wdata   <= d;
        wr      <= w;
        rd      <= !w;
        @(posedge clk_i);
        // no cycle count assumed: only the watchdog ends a stuck wait
        while (wait_req !== 1'b0) begin
            @(posedge clk_i);
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic wreg(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg

    task automatic creg(input string what, input logic [4:0] a,
                        input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask : creg

    task automatic poll(input int b);
        logic [31:0] q;
        int n;
        n = 0;
        q = 32'h0;
        while (q[b] !== 1'b1 && n < 200) begin
            bus(1'b0, OFS_ISTAT, 32'h0, q);
            n++;
        end
        chk("poll flag", 32'h1, {31'h0, q[b]});
    endtask : poll

    task automatic toggles(input int cyc, output int t);
        logic p;
        t = 0;
        p = sclk;
        repeat (cyc) begin
            @(posedge clk_i);
            if (sclk !== p) t++;
            p = sclk;
        end
    endtask : toggles

    task automatic half(output int h);
        int n;
        logic p;
        n = 0;
        h = 0;
        p = sclk;
        while (sclk === p && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        p = sclk;
        while (sclk === p && h < 200) begin
            @(posedge clk_i);
            h++;
        end
    endtask : half

    task automatic load_slave(input logic [35:0] s, input logic [5:0] n,
                              input logic i);
        @(posedge clk_i);
        stream <= s;
        len    <= n;
        inv    <= i;
        load   <= 1'b1;
        @(posedge clk_i);
        load   <= 1'b0;
    endtask : load_slave

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        int t;
        creg("ctrl", OFS_CTRL, 32'(CTRL_RESET));
        creg("div", OFS_DIV, 32'(DIV_RESET));
        creg("status", OFS_STATUS, 32'h0);
        creg("istat", OFS_ISTAT, 32'(IRQ_RESET));
        creg("ien", OFS_IEN, 32'(IRQ_RESET));
        creg("unmapped", 5'h1C, 32'h0);
        wreg(OFS_DIV, 32'h0000_0104);
        wreg(OFS_CTRL, 32'h0000_0007);
        creg("div back", OFS_DIV, 32'h0000_0104);
        toggles(40, t);
        chk("idle toggles", 32'h0, 32'(t));
        chk("clock oe", 32'h1, {31'h0, sclk_oe});
        $display("test reset_and_idle done");
    endtask : t_reset

    task automatic t_single;
        int t;
        int h;
        load_slave(36'h0_0000_00A5, 6'h08, 1'b0);
        wreg(OFS_IEN, 32'h1);
        creg("ien", OFS_IEN, 32'h1);
        wreg(OFS_CTRL, 32'h87);
        half(h);
        chk("half period", 32'h5, 32'(h));
        poll(IRQ_DONE);
        chk("irq raised", 32'h1, {31'h0, irq});
        creg("status", OFS_STATUS, 32'h4);
        creg("data", OFS_DATA, 32'hA5);
        creg("ctrl", OFS_CTRL, 32'h07);
        creg("status read", OFS_STATUS, 32'h0);
        toggles(40, t);
        chk("single stop", 32'h0, 32'(t));
        wreg(OFS_ICLR, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test single_word done");
    endtask : t_single

    task automatic t_cont;
        int t;
        logic [31:0] q;
        wreg(OFS_IEN, 32'h0);
        wreg(OFS_CTRL, 32'h4F);
        load_slave({18'h0, 9'h0A7, 9'h13C}, 6'h12, 1'b1);
        chk("idle inverted", 32'h1, {31'h0, sclk});
        wreg(OFS_CTRL, 32'h1CF);
        poll(IRQ_DONE);
        chk("irq masked", 32'h0, {31'h0, irq});
        wreg(OFS_ICLR, 32'h1);
        creg("status w1", OFS_STATUS, 32'h5);
        creg("data w1", OFS_DATA, 32'h3C);
        creg("ctrl kept", OFS_CTRL, 32'h1CF);
        poll(IRQ_DONE);
        creg("status w2", OFS_STATUS, 32'h4);
        creg("data w2", OFS_DATA, 32'hA7);
        poll(IRQ_ERR);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        chk("error set", 32'h1, {31'h0, q[STAT_ERR]});
        wreg(OFS_CTRL, 32'h4F);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        chk("error clear", 32'h0, {31'h0, q[STAT_ERR]});
        toggles(40, t);
        chk("cont stop", 32'h0, 32'(t));
        chk("idle after", 32'h1, {31'h0, sclk});
        $display("test continuous_ninth done");
    endtask : t_cont

    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset;
        t_single;
        t_cont;
        final_report;
    end

    // the scenarios need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        $display("Error watchdog expected done seen timeout");
        final_report;
    end
endmodule : sync_master_serial_receiver_tb
`default_nettype wire
